// *** rtl/bridge_cfg_pkg.sv ***
// Constants, register map and carrier types for the primary configuration block
//
// Contract
// - Command bit 0 set lets primary I/O be claimed; clear blocks it; resets zero.
// - Command bit 1 set lets primary memory be claimed; clear blocks it; resets zero.
// - Bit 2 clear: no primary master cycles, no secondary memory/I/O response.
// - Bit 2 set: master upstream memory and I/O forwarded from the secondary side.
// - Command bit 3 is read-only zero; no special cycles exist.
// - Command bit 4 reads zero except while forwarding for another master.
// - Bit 5 set claims primary I/O writes at 3C6h, 3C8h, 3C9h, AD[15:10] ignored.
// - Bit 6 set enables parity-error actions; clear lets errors be ignored.
// - Offset 00h bits 15:0 return a fixed maker code; writes ignored.
// - Offset 00h bits 31:16 return a fixed part code.
// - Status bit 24 sets on parity fault with bit 6 set; write one clears.
// - Command bits 15:10 are reserved and read zero.
package bridge_cfg_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_IDENT      = 8'h00;
    localparam logic [7:0] OFS_CMD_STATUS = 8'h04;
    localparam logic [7:0] OFS_HOTSWAP    = 8'h4C;
    localparam logic [7:0] OFS_UP_BASE_HI = 8'h54;
    localparam logic [7:0] OFS_UP_LIM_HI  = 8'h58;
    localparam logic [7:0] OFS_GPIO       = 8'h64;
    localparam logic [7:0] OFS_ERR_CLK    = 8'h68;
    localparam logic [7:0] OFS_PORT_CTL   = 8'h74;
    localparam logic [7:0] OFS_RETRY      = 8'h78;
    localparam logic [7:0] OFS_MTIMEOUT   = 8'h80;
    localparam logic [7:0] OFS_PM_CAP     = 8'hDC;
    localparam logic [7:0] OFS_PM_CSR     = 8'hE0;
    localparam logic [7:0] OFS_CAP3       = 8'hE4;

    // ------------------------------------------------------------------
    // Command and status field positions
    // ------------------------------------------------------------------
    localparam int CMD_IO_EN      = 0;
    localparam int CMD_MEM_EN     = 1;
    localparam int CMD_MASTER_EN  = 2;
    localparam int CMD_SPECIAL    = 3;
    localparam int CMD_MWI        = 4;
    localparam int CMD_PALETTE    = 5;
    localparam int CMD_PARITY_RSP = 6;
    localparam int CMD_STEPPING   = 7;
    localparam int CMD_SYSERR_EN  = 8;
    localparam int CMD_FAST_B2B   = 9;
    localparam int STS_PARITY_DET = 24;

    // Writable command bits: 0,1,2,5,6,8,9
    localparam logic [15:0] CMD_WR_MASK  = 16'h0367;
    localparam logic [15:0] CMD_RESET    = 16'h0000;
    // Fixed status bits: capability list, 66 MHz, fast back-to-back, medium select
    localparam logic [15:0] STS_FIXED    = 16'h02B0;

    // ------------------------------------------------------------------
    // Palette snoop decode
    // ------------------------------------------------------------------
    localparam logic [9:0] PAL_ADDR_A = 10'h3C6;
    localparam logic [9:0] PAL_ADDR_B = 10'h3C8;
    localparam logic [9:0] PAL_ADDR_C = 10'h3C9;

    // Arbitrary identity codes, not those of any real part
    localparam logic [15:0] MAKER_ID_DEFAULT = 16'h1A2B;
    localparam logic [15:0] PART_ID_DEFAULT  = 16'h3C4D;

    localparam logic [31:0] WORD_RESET = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [7:0]  addr;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } cfg_rsp_t;

    typedef struct packed {
        logic        valid;
        logic        is_io;
        logic        is_mem;
        logic        write;
        logic [15:0] addr;
    } bus_cyc_t;

    typedef struct packed {
        logic io_en;
        logic mem_en;
        logic master_en;
        logic mwi_en;
        logic palette_en;
        logic parity_rsp;
        logic stepping;
        logic syserr_en;
        logic fast_b2b;
    } cmd_ctl_t;

endpackage

// *** rtl/cmd_reg_bits.sv ***
// Command and status word storage with write masks and sticky parity flag
`timescale 1ns/10ps
module cmd_reg_bits (
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    // Write access
    input  wire logic                   i_wr,
    input  wire logic [3:0]             i_byte_en,
    input  wire logic [31:0]            i_wdata,
    // Events
    input  wire logic                   i_parity_fault,
    input  wire logic                   i_fwd_mwi,
    // State
    output logic [31:0]                 o_word,
    output bridge_cfg_pkg::cmd_ctl_t    o_ctl
);
    import bridge_cfg_pkg::*;

    logic [15:0] cmd_reg;
    logic        par_det_reg;
    logic [15:0] wmask;

    assign wmask = {{8{i_byte_en[1]}}, {8{i_byte_en[0]}}} & CMD_WR_MASK;

    // ------------------------------------------------------------------
    // Command bits
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            cmd_reg <= CMD_RESET;
        end else if (i_wr) begin
            cmd_reg <= (cmd_reg & ~wmask) | (i_wdata[15:0] & wmask);
        end
    end

    // ------------------------------------------------------------------
    // Parity detected, set wins over write-one clear
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            par_det_reg <= 1'b0;
        end else if (i_parity_fault && cmd_reg[CMD_PARITY_RSP]) begin
            par_det_reg <= 1'b1;
        end else if (i_wr && i_byte_en[3] && i_wdata[STS_PARITY_DET]) begin
            par_det_reg <= 1'b0;
        end
    end

    assign o_word = {STS_FIXED[15:9], par_det_reg, STS_FIXED[7:0],
                     6'h00,
                     cmd_reg[9:5],
                     i_fwd_mwi,
                     1'b0,
                     cmd_reg[2:0]};

    assign o_ctl.io_en      = cmd_reg[CMD_IO_EN];
    assign o_ctl.mem_en     = cmd_reg[CMD_MEM_EN];
    assign o_ctl.master_en  = cmd_reg[CMD_MASTER_EN];
    assign o_ctl.mwi_en     = i_fwd_mwi;
    assign o_ctl.palette_en = cmd_reg[CMD_PALETTE];
    assign o_ctl.parity_rsp = cmd_reg[CMD_PARITY_RSP];
    assign o_ctl.stepping   = cmd_reg[CMD_STEPPING];
    assign o_ctl.syserr_en  = cmd_reg[CMD_SYSERR_EN];
    assign o_ctl.fast_b2b   = cmd_reg[CMD_FAST_B2B];

endmodule

// *** rtl/cycle_gate.sv ***
// Decides whether primary or secondary cycles are claimed under the command bits
`timescale 1ns/10ps
module cycle_gate (
    // Control
    input  bridge_cfg_pkg::cmd_ctl_t    i_ctl,
    // Observed cycles
    input  bridge_cfg_pkg::bus_cyc_t    i_pri_cyc,
    input  bridge_cfg_pkg::bus_cyc_t    i_sec_cyc,
    input  wire logic                   i_up_req,
    // Decisions
    output logic                        o_pri_claim,
    output logic                        o_pal_claim,
    output logic                        o_sec_claim,
    output logic                        o_up_master
);
    import bridge_cfg_pkg::*;

    function automatic logic is_palette(input logic [15:0] a);
        is_palette = (a[9:0] == PAL_ADDR_A) || (a[9:0] == PAL_ADDR_B)
                   || (a[9:0] == PAL_ADDR_C);
    endfunction

    always_comb begin
        o_pal_claim = i_pri_cyc.valid && i_pri_cyc.is_io && i_pri_cyc.write
                    && i_ctl.palette_en && is_palette(i_pri_cyc.addr);
        o_pri_claim = i_pri_cyc.valid
                    && ((i_pri_cyc.is_io && i_ctl.io_en)
                     || (i_pri_cyc.is_mem && i_ctl.mem_en));
        o_sec_claim = i_sec_cyc.valid && i_ctl.master_en
                    && (i_sec_cyc.is_io || i_sec_cyc.is_mem);
        o_up_master = i_up_req && i_ctl.master_en;
    end

endmodule

// *** rtl/bridge_primary_command_config.sv ***
// Primary-side configuration register bank and command gating
`timescale 1ns/10ps
module bridge_primary_command_config #(
    parameter logic [15:0] MAKER_ID = bridge_cfg_pkg::MAKER_ID_DEFAULT, // arbitrary value
    parameter logic [15:0] PART_ID  = bridge_cfg_pkg::PART_ID_DEFAULT   // arbitrary value
) (
    // Clock and reset
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_rst,
    // Configuration access
    input  bridge_cfg_pkg::cfg_req_t    i_cfg_req,
    output bridge_cfg_pkg::cfg_rsp_t    o_cfg_rsp,
    // Observed bus cycles
    input  bridge_cfg_pkg::bus_cyc_t    i_pri_cyc,
    input  bridge_cfg_pkg::bus_cyc_t    i_sec_cyc,
    input  wire logic                   i_up_req,
    input  wire logic                   i_fwd_mwi,
    // Error inputs (parity fault pin active low, system error event active high)
    input  wire logic                   i_primary_parity_fault_pin_n,
    input  wire logic                   i_syserr_event,
    // Decisions and control
    output logic                        o_pri_claim,
    output logic                        o_pal_claim,
    output logic                        o_sec_claim,
    output logic                        o_up_master,
    output logic                        o_parity_act,
    output logic                        o_primary_system_fault_pin_n,
    output logic                        o_primary_system_fault_pin_oe_n,
    output bridge_cfg_pkg::cmd_ctl_t    o_ctl
);
    import bridge_cfg_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [31:0]  cmd_word;
    cmd_ctl_t     ctl;
    logic         wr;
    logic         pri_claim, pal_claim, sec_claim, up_master;
    logic [31:0]  rw_reg [0:10];
    logic [31:0]  rd_next;
    logic [3:0]   idx;
    logic         hit;

    function automatic logic [3:0] map_index(input logic [7:0] a);
        case (a)
            OFS_HOTSWAP:    map_index = 4'h0;
            OFS_UP_BASE_HI: map_index = 4'h1;
            OFS_UP_LIM_HI:  map_index = 4'h2;
            OFS_GPIO:       map_index = 4'h3;
            OFS_ERR_CLK:    map_index = 4'h4;
            OFS_PORT_CTL:   map_index = 4'h5;
            OFS_RETRY:      map_index = 4'h6;
            OFS_MTIMEOUT:   map_index = 4'h7;
            OFS_PM_CAP:     map_index = 4'h8;
            OFS_PM_CSR:     map_index = 4'h9;
            OFS_CAP3:       map_index = 4'hA;
            default:        map_index = 4'hF;
        endcase
    endfunction

    function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        be_merge = (old_v & ~m) | (new_v & m);
    endfunction

    assign wr  = i_cfg_req.valid && i_cfg_req.write && (i_cfg_req.addr == OFS_CMD_STATUS);
    assign idx = map_index(i_cfg_req.addr);
    assign hit = (idx != 4'hF);

    // ------------------------------------------------------------------
    // Command and status
    // ------------------------------------------------------------------
    cmd_reg_bits u_cmd (
        .i_clk_sys      (i_clk_sys),
        .i_rst          (i_rst),
        .i_wr           (wr),
        .i_byte_en      (i_cfg_req.byte_en),
        .i_wdata        (i_cfg_req.wdata),
        .i_parity_fault (~i_primary_parity_fault_pin_n),
        .i_fwd_mwi      (i_fwd_mwi),
        .o_word         (cmd_word),
        .o_ctl          (ctl)
    );

    cycle_gate u_gate (
        .i_ctl       (ctl),
        .i_pri_cyc   (i_pri_cyc),
        .i_sec_cyc   (i_sec_cyc),
        .i_up_req    (i_up_req),
        .o_pri_claim (pri_claim),
        .o_pal_claim (pal_claim),
        .o_sec_claim (sec_claim),
        .o_up_master (up_master)
    );

    // ------------------------------------------------------------------
    // Plain storage for the remaining mapped words
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < 11; k++) begin
                rw_reg[k] <= WORD_RESET;
            end
        end else if (i_cfg_req.valid && i_cfg_req.write && hit) begin
            rw_reg[idx] <= be_merge(rw_reg[idx], i_cfg_req.wdata, i_cfg_req.byte_en);
        end
    end

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    always_comb begin
        rd_next = WORD_RESET;
        if (i_cfg_req.addr == OFS_IDENT) begin
            rd_next = {PART_ID, MAKER_ID};
        end else if (i_cfg_req.addr == OFS_CMD_STATUS) begin
            rd_next = cmd_word;
        end else if (hit) begin
            rd_next = rw_reg[idx];
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_cfg_rsp <= '0;
        end else begin
            o_cfg_rsp.valid <= i_cfg_req.valid;
            o_cfg_rsp.rdata <= (i_cfg_req.valid && !i_cfg_req.write) ? rd_next : WORD_RESET;
        end
    end

    // ------------------------------------------------------------------
    // Registered decisions
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_pri_claim  <= 1'b0;
            o_pal_claim  <= 1'b0;
            o_sec_claim  <= 1'b0;
            o_up_master  <= 1'b0;
            o_parity_act <= 1'b0;
            o_ctl        <= '0;
        end else begin
            o_pri_claim  <= pri_claim;
            o_pal_claim  <= pal_claim;
            o_sec_claim  <= sec_claim;
            o_up_master  <= up_master;
            o_parity_act <= ~i_primary_parity_fault_pin_n & ctl.parity_rsp;
            o_ctl        <= ctl;
        end
    end

    // System fault pin: open drain, driven low only when enabled
    always_ff @(posedge i_clk_sys or posedge i_rst) begin
        if (i_rst) begin
            o_primary_system_fault_pin_n    <= 1'b1;
            o_primary_system_fault_pin_oe_n <= 1'b1;
        end else begin
            o_primary_system_fault_pin_n    <= 1'b0;
            o_primary_system_fault_pin_oe_n <= ~(i_syserr_event & ctl.syserr_en);
        end
    end

endmodule

// *** tb/bridge_cfg_asserts.sv ***
// Assertion checker for the primary configuration block
`timescale 1ns/10ps
module bridge_cfg_asserts #(
    parameter logic [15:0] MAKER_ID = 16'h0000,
    parameter logic [15:0] PART_ID  = 16'h0000
) (
    // Clock, reset and access
    input  wire logic                i_clk_sys,
    input  wire logic                i_rst,
    input  bridge_cfg_pkg::cfg_req_t i_cfg_req,
    input  bridge_cfg_pkg::cfg_rsp_t o_cfg_rsp,
    // Observed cycles and decisions
    input  bridge_cfg_pkg::bus_cyc_t i_pri_cyc,
    input  bridge_cfg_pkg::bus_cyc_t i_sec_cyc,
    input  wire logic                i_up_req,
    input  wire logic                i_fwd_mwi,
    input  wire logic                i_primary_parity_fault_pin_n,
    input  wire logic                o_pri_claim,
    input  wire logic                o_pal_claim,
    input  wire logic                o_sec_claim,
    input  wire logic                o_up_master,
    input  wire logic                o_parity_act,
    input  bridge_cfg_pkg::cmd_ctl_t o_ctl
);
    import bridge_cfg_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    sequence s_read(logic [7:0] a);
        i_cfg_req.valid && !i_cfg_req.write && i_cfg_req.addr == a ##1 o_cfg_rsp.valid;
    endsequence
    // Enable held low across the decision edge, so a lagging copy cannot mislead
    property p_gate(logic c, logic en, logic q);
        c && !en ##1 !en |-> !q;
    endproperty

    chk_rsp_latency: assert property (o_cfg_rsp.valid == $past(i_cfg_req.valid))
        else $error("config answer not one cycle after request");
    chk_ident_word: assert property (s_read(OFS_IDENT)
        |-> o_cfg_rsp.rdata == {PART_ID, MAKER_ID}) else $error("identity word wrong");
    chk_cmd_fixed: assert property (s_read(OFS_CMD_STATUS)
        |-> o_cfg_rsp.rdata[15:10] == 6'h00 && !o_cfg_rsp.rdata[3])
        else $error("fixed command bits not zero");
    chk_mwi_zero: assert property (i_cfg_req.valid && !i_cfg_req.write &&
        i_cfg_req.addr == OFS_CMD_STATUS && !i_fwd_mwi ##1 !i_fwd_mwi |-> !o_cfg_rsp.rdata[4])
        else $error("invalidate bit set while not forwarding");
    chk_io_block: assert property (p_gate(i_pri_cyc.valid && i_pri_cyc.is_io
        && !i_pri_cyc.is_mem, o_ctl.io_en, o_pri_claim)) else $error("I/O claimed while off");
    chk_mem_block: assert property (p_gate(i_pri_cyc.valid && i_pri_cyc.is_mem
        && !i_pri_cyc.is_io, o_ctl.mem_en, o_pri_claim)) else $error("memory claimed while off");
    chk_sec_block: assert property (p_gate(i_sec_cyc.valid, o_ctl.master_en, o_sec_claim))
        else $error("secondary answered while mastering off");
    chk_up_block: assert property (p_gate(i_up_req, o_ctl.master_en, o_up_master))
        else $error("upstream mastering while off");
    chk_pal_block: assert property (p_gate(i_pri_cyc.valid && i_pri_cyc.is_io
        && i_pri_cyc.write, o_ctl.palette_en, o_pal_claim)) else $error("palette claimed while off");
    chk_parity_quiet: assert property (p_gate(!i_primary_parity_fault_pin_n,
        o_ctl.parity_rsp, o_parity_act)) else $error("parity action while off");
endmodule

bind bridge_primary_command_config bridge_cfg_asserts #(
    .MAKER_ID(MAKER_ID),
    .PART_ID (PART_ID)
) u_bridge_cfg_asserts (
    .i_clk_sys, .i_rst, .i_cfg_req, .o_cfg_rsp, .i_pri_cyc, .i_sec_cyc, .i_up_req,
    .i_fwd_mwi, .i_primary_parity_fault_pin_n, .o_pri_claim, .o_pal_claim,
    .o_sec_claim, .o_up_master, .o_parity_act, .o_ctl
);

// *** tb/pci_host_model.sv ***
// Configuration master on the primary side
`timescale 1ns/10ps
module pci_host_model (
    // Clock
    input  wire logic                i_clk_sys,
    // Configuration access
    output bridge_cfg_pkg::cfg_req_t o_cfg_req,
    input  bridge_cfg_pkg::cfg_rsp_t i_cfg_rsp
);
    import bridge_cfg_pkg::*;
    initial o_cfg_req = '0;

    // One request per access; released lines carry inverted data
    task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q, output logic ok);
        @(posedge i_clk_sys);
        #1 o_cfg_req = '{valid: 1'b1, write: wr, addr: a, byte_en: 4'hF, wdata: d};
        @(posedge i_clk_sys);
        #1 o_cfg_req = '{valid: 1'b0, write: ~wr, addr: ~a, byte_en: 4'h0, wdata: ~d};
        ok = (i_cfg_rsp.valid === 1'b1);
        q = i_cfg_rsp.rdata;
    endtask
endmodule

// *** tb/bridge_primary_command_config_bench.sv ***
// Self-checking bench for the primary configuration block
`timescale 1ns/10ps
module bridge_primary_command_config_bench;
    import bridge_cfg_pkg::*;
    localparam logic [15:0] TB_MAKER = 16'h5A01; // arbitrary value
    localparam logic [15:0] TB_PART  = 16'h6B02; // arbitrary value
    localparam bus_cyc_t    IDLE     = '0;
    logic     clk;
    logic     rst     = 1'b1;
    bus_cyc_t pri     = '0;
    bus_cyc_t sec     = '0;
    logic     up_req  = 1'b0;
    logic     fwd_mwi = 1'b0;
    logic     perr_n  = 1'b1;
    logic     serr_ev = 1'b0;
    cfg_req_t cfg_req;
    cfg_rsp_t cfg_rsp;
    logic     pri_claim;
    logic     pal_claim;
    logic     sec_claim;
    logic     up_master;
    logic     parity_act;
    logic     serr_pin_n;
    logic     serr_oe_n;
    cmd_ctl_t ctl_q;
    int       error_cnt = 0;
    int       tests_run = 0;
    logic [9:0] pal_addr [3] = '{PAL_ADDR_A, PAL_ADDR_B, PAL_ADDR_C};

    bridge_primary_command_config #(.MAKER_ID(TB_MAKER), .PART_ID(TB_PART))
    u_bridge_primary_command_config (
        .i_clk_sys(clk), .i_rst(rst), .i_cfg_req(cfg_req), .o_cfg_rsp(cfg_rsp),
        .i_pri_cyc(pri), .i_sec_cyc(sec), .i_up_req(up_req), .i_fwd_mwi(fwd_mwi),
        .i_primary_parity_fault_pin_n(perr_n), .i_syserr_event(serr_ev),
        .o_pri_claim(pri_claim), .o_pal_claim(pal_claim), .o_sec_claim(sec_claim),
        .o_up_master(up_master), .o_parity_act(parity_act),
        .o_primary_system_fault_pin_n(serr_pin_n), .o_primary_system_fault_pin_oe_n(serr_oe_n),
        .o_ctl(ctl_q)
    );
    pci_host_model u_pci_host_model (.i_clk_sys(clk), .o_cfg_req(cfg_req), .i_cfg_rsp(cfg_rsp));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // ------------------------------------------------------------------
    // Access and comparison tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        ok;
        u_pci_host_model.access(1'b1, a, d, q, ok);
        check({31'h0, ok}, 32'h1);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        ok;
        u_pci_host_model.access(1'b0, a, 32'h0, q, ok);
        check({31'h0, ok}, 32'h1);
        check(q, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    function automatic bus_cyc_t mk(input logic io, input logic w, input logic [15:0] a);
        return '{valid: 1'b1, is_io: io, is_mem: ~io, write: w, addr: a};
    endfunction
    // One observed cycle; decisions {primary, palette, secondary, upstream}
    task automatic cyc(input bus_cyc_t p, input bus_cyc_t s, input logic u, input logic [3:0] e);
        @(posedge clk);
        #1 pri = p;
        sec = s;
        up_req = u;
        @(posedge clk);
        #1 pri = {1'b0, ~p[18:0]};
        sec = {1'b0, ~s[18:0]};
        up_req = 1'b0;
        check({28'h0, pri_claim, pal_claim, sec_claim, up_master}, {28'h0, e});
    endtask
    task automatic pulse_perr(input logic exp);
        settle();
        perr_n = 1'b0;
        @(posedge clk);
        #1 perr_n = 1'b1;
        check({31'h0, parity_act}, {31'h0, exp});
    endtask
    task automatic done(input string name);
        $display("test %s finished", name);
    endtask
    task automatic report_and_stop();
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        report_and_stop();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        #1 rst = 1'b0;
        rd(OFS_CMD_STATUS, {STS_FIXED, CMD_RESET});
        rd(OFS_IDENT, {TB_PART, TB_MAKER});
        wr(OFS_IDENT, 32'hFFFF_FFFF);
        rd(OFS_IDENT, {TB_PART, TB_MAKER});
        wr(OFS_CMD_STATUS, 32'hFFFF_FFFF);
        rd(OFS_CMD_STATUS, {STS_FIXED, CMD_WR_MASK});
        fwd_mwi = 1'b1;
        rd(OFS_CMD_STATUS, {STS_FIXED, CMD_WR_MASK | 16'h0010});
        fwd_mwi = 1'b0;
        wr(8'h5C, 32'hFFFF_FFFF);
        rd(8'h5C, 32'h0000_0000);
        wr(OFS_HOTSWAP, 32'hA5A5_5A5A);
        rd(OFS_HOTSWAP, 32'hA5A5_5A5A);
        done("register access");
        for (int en = 0; en < 2; en++) begin
            wr(OFS_CMD_STATUS, en[0] ? 32'h0000_0027 : 32'h0000_0000);
            settle();
            check({23'h0, ctl_q}, en[0] ? 32'h0000_01D0 : 32'h0000_0000);
            cyc(mk(1'b1, 1'b0, 16'h1000), IDLE, 1'b0, {en[0], 3'b000});
            cyc(mk(1'b0, 1'b1, 16'h2000), IDLE, 1'b0, {en[0], 3'b000});
            cyc(IDLE, mk(1'b1, 1'b1, 16'h0300), 1'b0, {2'b00, en[0], 1'b0});
            cyc(IDLE, IDLE, 1'b1, {3'b000, en[0]});
            for (int i = 0; i < 3; i++)
                cyc(mk(1'b1, 1'b1, {6'h2A, pal_addr[i]}), IDLE, 1'b0, {{2{en[0]}}, 2'b00});
            cyc(mk(1'b1, 1'b1, 16'h03C7), IDLE, 1'b0, {en[0], 3'b000});
        end
        done("command gating");
        wr(OFS_CMD_STATUS, 32'h0000_0040);
        pulse_perr(1'b1);
        rd(OFS_CMD_STATUS, {STS_FIXED | 16'h0100, 16'h0040});
        wr(OFS_CMD_STATUS, 32'h0100_0040);
        rd(OFS_CMD_STATUS, {STS_FIXED, 16'h0040});
        wr(OFS_CMD_STATUS, 32'h0000_0000);
        pulse_perr(1'b0);
        rd(OFS_CMD_STATUS, {STS_FIXED, 16'h0000});
        done("parity handling");
        for (int en = 0; en < 2; en++) begin
            wr(OFS_CMD_STATUS, en[0] ? 32'h0000_0100 : 32'h0000_0000);
            serr_ev = 1'b1;
            @(posedge clk);
            #1 serr_ev = 1'b0;
            check({30'h0, serr_pin_n, serr_oe_n}, {31'h0, ~en[0]});
            @(posedge clk);
            #1 check({30'h0, serr_pin_n, serr_oe_n}, 32'h0000_0001);
        end
        done("system fault pin");
        report_and_stop();
    end
endmodule
